// ---- pkg/arg_pkg.sv ----
package arg_pkg;

	// Clock and timing
	localparam int unsigned ARG_CLK_HZ = 25000000;
	localparam int unsigned ARG_TICK_MS = 100;
	localparam int unsigned ARG_HOLD_MS = 100;
	localparam int unsigned ARG_TICK_CYC = ARG_CLK_HZ / 1000 * ARG_TICK_MS;
	localparam int unsigned ARG_HOLD_CYC = ARG_CLK_HZ / 1000 * ARG_HOLD_MS;

	// Widths
	localparam int ARG_PAR_W = 16;
	localparam int ARG_LVL_W = 24;
	localparam int ARG_NUM_W = 24;
	localparam int ARG_CNT_W = 32;

	// Register byte offsets
	localparam logic [7:0] ARG_REG_CTRL = 8'h00;
	localparam logic [7:0] ARG_REG_STATUS = 8'h04;
	localparam logic [7:0] ARG_REG_FIRST_TGT = 8'h08;
	localparam logic [7:0] ARG_REG_SECOND_TGT = 8'h0c;
	localparam logic [7:0] ARG_REG_MAX_LEVEL = 8'h10;
	localparam logic [7:0] ARG_REG_SS_OFFSET = 8'h14;
	localparam logic [7:0] ARG_REG_RATE = 8'h18;
	localparam logic [7:0] ARG_REG_GAIN = 8'h1c;
	localparam logic [7:0] ARG_REG_BASE_OFS = 8'h20;
	localparam logic [7:0] ARG_REG_LEVEL = 8'h24;
	localparam logic [7:0] ARG_REG_AQ = 8'h28;

	// Control field positions
	localparam int ARG_CTRL_EN_BIT = 0;
	localparam int ARG_CTRL_SEL_BIT = 1;
	localparam int ARG_CTRL_STOP_BIT = 2;

	// Parameter ranges
	localparam int ARG_LEVEL_MIN = -10000;
	localparam int ARG_LEVEL_MAX = 20000;
	localparam int ARG_SS_MIN = 0;
	localparam int ARG_SS_MAX = 20000;
	localparam int ARG_RATE_MIN = 1;
	localparam int ARG_RATE_MAX = 10000;
	localparam int ARG_GAIN_MIN = 0;
	localparam int ARG_GAIN_MAX = 1000;
	localparam int ARG_OFS_MIN = -10000;
	localparam int ARG_OFS_MAX = 10000;
	localparam logic [ARG_NUM_W-1:0] ARG_AQ_MAX = 24'h007fff;

	// Scaling: level kept in tenths, gain in hundredths
	localparam logic signed [ARG_LVL_W-1:0] ARG_STEP_DIV = 24'sh00000a;
	localparam logic [ARG_NUM_W-1:0] ARG_GAIN_SCALE = 24'h000064;

	// Reset values
	localparam logic [2:0] ARG_CTRL_RST = 3'h0;
	localparam logic signed [ARG_PAR_W-1:0] ARG_TGT_RST = 16'sh0000;
	localparam logic signed [ARG_PAR_W-1:0] ARG_MAX_RST = 16'sh4e20;
	localparam logic signed [ARG_PAR_W-1:0] ARG_SS_RST = 16'sh0000;
	localparam logic signed [ARG_PAR_W-1:0] ARG_RATE_RST = 16'sh0001;
	localparam logic signed [ARG_PAR_W-1:0] ARG_GAIN_RST = 16'sh0064;
	localparam logic signed [ARG_PAR_W-1:0] ARG_OFS_RST = 16'sh0000;

	typedef enum logic [2:0] {
		ARG_IDLE,
		ARG_HOLD_START,
		ARG_RAMP,
		ARG_DECEL,
		ARG_HOLD_STOP,
		ARG_LOCKED
	} arg_state_e;

endpackage : arg_pkg

// ---- rtl/arg_divider.sv ----
`timescale 1ns/1ps
module arg_divider
	import arg_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Request
	input wire logic start,
	input wire logic [ARG_NUM_W-1:0] numer,
	input wire logic [ARG_PAR_W-1:0] denom,
	// Answer
	output logic busy,
	output logic done,
	output logic [ARG_NUM_W-1:0] quot
);

	logic [ARG_PAR_W:0] rem_ff;
	logic [ARG_NUM_W-1:0] shq_ff;
	logic [ARG_PAR_W-1:0] den_ff;
	logic [4:0] cnt_ff;
	logic busy_ff;
	logic done_ff;
	logic [ARG_NUM_W-1:0] quot_ff;

	wire [ARG_PAR_W:0] trial = {rem_ff[ARG_PAR_W-1:0], shq_ff[ARG_NUM_W-1]};
	wire fits = trial >= {1'b0, den_ff};
	wire [ARG_PAR_W:0] nxt_rem = fits ? trial - {1'b0, den_ff} : trial;
	wire [ARG_NUM_W-1:0] nxt_shq = {shq_ff[ARG_NUM_W-2:0], fits};
	wire last = cnt_ff == 5'(ARG_NUM_W - 1);

	// Restoring division, one quotient bit per cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rem_ff <= '0;
			shq_ff <= '0;
			den_ff <= '0;
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			quot_ff <= '0;
		end
		else if (!busy_ff)
		begin
			done_ff <= 1'b0;
			if (start)
			begin
				rem_ff <= '0;
				shq_ff <= numer;
				den_ff <= denom;
				cnt_ff <= '0;
				busy_ff <= 1'b1;
			end
		end
		else
		begin
			rem_ff <= nxt_rem;
			shq_ff <= nxt_shq;
			cnt_ff <= cnt_ff + 5'h01;
			if (last)
			begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
				quot_ff <= nxt_shq;
			end
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
	assign quot = quot_ff;

endmodule : arg_divider

// ---- rtl/arg_ramp_top.sv ----
`timescale 1ns/1ps
module arg_ramp_top
	import arg_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = ARG_TICK_CYC,
	parameter int unsigned HOLD_CYCLES = ARG_HOLD_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Ramp results
	output logic [15:0] scaled_analog_out,
	output logic signed [15:0] current_level,
	output logic ramp_running
);

	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction : wb_merge

	function automatic logic signed [ARG_PAR_W-1:0] par_clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		logic signed [31:0] r;
		r = (v < lo) ? lo : ((v > hi) ? hi : v);
		return r[ARG_PAR_W-1:0];
	endfunction : par_clamp

	function automatic logic signed [ARG_LVL_W-1:0] to_x10(input logic signed [ARG_PAR_W-1:0] v);
		logic signed [ARG_LVL_W-1:0] w;
		w = {{(ARG_LVL_W-ARG_PAR_W){v[ARG_PAR_W-1]}}, v};
		return w * ARG_STEP_DIV;
	endfunction : to_x10

	function automatic logic signed [ARG_LVL_W-1:0] cap(input logic signed [ARG_LVL_W-1:0] v,
		input logic signed [ARG_LVL_W-1:0] hi);
		return (v > hi) ? hi : v;
	endfunction : cap

	// Registers
	logic [2:0] ctrl_ff;
	logic signed [ARG_PAR_W-1:0] first_tgt_ff;
	logic signed [ARG_PAR_W-1:0] second_tgt_ff;
	logic signed [ARG_PAR_W-1:0] max_level_ff;
	logic signed [ARG_PAR_W-1:0] ss_offset_ff;
	logic signed [ARG_PAR_W-1:0] rate_ff;
	logic signed [ARG_PAR_W-1:0] gain_ff;
	logic signed [ARG_PAR_W-1:0] base_ofs_ff;
	logic ack_ff;
	logic [31:0] dat_ff;

	// Ramp state
	arg_state_e state_ff;
	arg_state_e nxt_state;
	logic signed [ARG_LVL_W-1:0] level_ff;
	logic signed [ARG_LVL_W-1:0] nxt_level;
	logic [ARG_CNT_W-1:0] hold_ff;
	logic [ARG_CNT_W-1:0] nxt_hold;
	logic [ARG_CNT_W-1:0] tick_cnt_ff;
	logic tick_ff;
	logic en_q_ff;
	logic [15:0] aq_ff;
	logic signed [15:0] lvl_out_ff;
	logic running_ff;
	logic zero_ff;

	// Bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire bus_wr = bus_req & wb_we_i;

	function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] reg_ofs,
		input logic wr);
		return wr && (adr == reg_ofs);
	endfunction : wr_hit

	wire [31:0] merged_ctrl = wb_merge({29'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
	wire [31:0] merged_first = wb_merge(32'(first_tgt_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_second = wb_merge(32'(second_tgt_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_max = wb_merge(32'(max_level_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_ss = wb_merge(32'(ss_offset_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_rate = wb_merge(32'(rate_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_gain = wb_merge(32'(gain_ff), wb_dat_i, wb_sel_i);
	wire [31:0] merged_ofs = wb_merge(32'(base_ofs_ff), wb_dat_i, wb_sel_i);

	wire [31:0] rd_data =
		(wb_adr_i == ARG_REG_CTRL) ? {29'h0, ctrl_ff} :
		(wb_adr_i == ARG_REG_STATUS) ? {28'h0, running_ff, 3'(state_ff)} :
		(wb_adr_i == ARG_REG_FIRST_TGT) ? 32'(first_tgt_ff) :
		(wb_adr_i == ARG_REG_SECOND_TGT) ? 32'(second_tgt_ff) :
		(wb_adr_i == ARG_REG_MAX_LEVEL) ? 32'(max_level_ff) :
		(wb_adr_i == ARG_REG_SS_OFFSET) ? 32'(ss_offset_ff) :
		(wb_adr_i == ARG_REG_RATE) ? 32'(rate_ff) :
		(wb_adr_i == ARG_REG_GAIN) ? 32'(gain_ff) :
		(wb_adr_i == ARG_REG_BASE_OFS) ? 32'(base_ofs_ff) :
		(wb_adr_i == ARG_REG_LEVEL) ? 32'(lvl_out_ff) :
		(wb_adr_i == ARG_REG_AQ) ? {16'h0, aq_ff} :
		32'h0;

	// Bus slave: ack one cycle after the request is seen
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_ff <= 1'b0;
			dat_ff <= '0;
		end
		else
		begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i)
				dat_ff <= rd_data;
		end
	end

	// Parameter writes are limited to their legal ranges
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_ff <= ARG_CTRL_RST;
			first_tgt_ff <= ARG_TGT_RST;
			second_tgt_ff <= ARG_TGT_RST;
			max_level_ff <= ARG_MAX_RST;
			ss_offset_ff <= ARG_SS_RST;
			rate_ff <= ARG_RATE_RST;
			gain_ff <= ARG_GAIN_RST;
			base_ofs_ff <= ARG_OFS_RST;
		end
		else
		begin
			if (wr_hit(wb_adr_i, ARG_REG_CTRL, bus_wr))
				ctrl_ff <= merged_ctrl[2:0];
			if (wr_hit(wb_adr_i, ARG_REG_FIRST_TGT, bus_wr))
				first_tgt_ff <= par_clamp(merged_first, ARG_LEVEL_MIN, ARG_LEVEL_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_SECOND_TGT, bus_wr))
				second_tgt_ff <= par_clamp(merged_second, ARG_LEVEL_MIN, ARG_LEVEL_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_MAX_LEVEL, bus_wr))
				max_level_ff <= par_clamp(merged_max, ARG_LEVEL_MIN, ARG_LEVEL_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_SS_OFFSET, bus_wr))
				ss_offset_ff <= par_clamp(merged_ss, ARG_SS_MIN, ARG_SS_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_RATE, bus_wr))
				rate_ff <= par_clamp(merged_rate, ARG_RATE_MIN, ARG_RATE_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_GAIN, bus_wr))
				gain_ff <= par_clamp(merged_gain, ARG_GAIN_MIN, ARG_GAIN_MAX);
			if (wr_hit(wb_adr_i, ARG_REG_BASE_OFS, bus_wr))
				base_ofs_ff <= par_clamp(merged_ofs, ARG_OFS_MIN, ARG_OFS_MAX);
		end
	end

	// Control inputs live in one register, so no synchroniser is needed
	wire en = ctrl_ff[ARG_CTRL_EN_BIT];
	wire sel = ctrl_ff[ARG_CTRL_SEL_BIT];
	wire stop = ctrl_ff[ARG_CTRL_STOP_BIT];
	wire en_rise = en & ~en_q_ff;
	wire en_fall = ~en & en_q_ff;

	// Levels in tenths of a step; every one of them capped at the maximum
	wire signed [ARG_LVL_W-1:0] max_x10 = to_x10(max_level_ff);
	wire signed [ARG_LVL_W-1:0] base_x10 = cap(to_x10(base_ofs_ff), max_x10);
	wire signed [ARG_LVL_W-1:0] ss_x10 = cap(to_x10(base_ofs_ff) + to_x10(ss_offset_ff),
		max_x10);
	wire signed [ARG_PAR_W-1:0] tgt_sel = sel ? second_tgt_ff : first_tgt_ff;
	wire signed [ARG_LVL_W-1:0] tgt_x10 = cap(to_x10(tgt_sel), max_x10);
	wire signed [ARG_LVL_W-1:0] goal = (state_ff == ARG_DECEL) ? ss_x10 : tgt_x10;
	// Rate in steps per second equals tenths of a step per 100 ms tick
	wire signed [ARG_LVL_W-1:0] rate_w = {{(ARG_LVL_W-ARG_PAR_W){1'b0}}, rate_ff};
	wire signed [ARG_LVL_W-1:0] lvl_up = level_ff + rate_w;
	wire signed [ARG_LVL_W-1:0] lvl_dn = level_ff - rate_w;
	wire signed [ARG_LVL_W-1:0] ramp_step = (level_ff < goal) ?
		((lvl_up > goal) ? goal : lvl_up) :
		((lvl_dn < goal) ? goal : lvl_dn);
	wire hold_done = hold_ff == ARG_CNT_W'(HOLD_CYCLES - 1);

	// Update tick divider
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= tick_cnt_ff == ARG_CNT_W'(TICK_CYCLES - 1);
			if (tick_cnt_ff == ARG_CNT_W'(TICK_CYCLES - 1))
				tick_cnt_ff <= '0;
			else
				tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		nxt_hold = hold_ff;
		case (state_ff)
			ARG_IDLE:
			begin
				nxt_level = base_x10;
				if (en_rise && !stop)
				begin
					nxt_state = ARG_HOLD_START;
					nxt_level = ss_x10;
					nxt_hold = '0;
				end
			end
			ARG_HOLD_START:
			begin
				nxt_level = ss_x10;
				nxt_hold = hold_ff + 1'b1;
				if (hold_done)
					nxt_state = ARG_RAMP;
			end
			ARG_RAMP:
			begin
				if (tick_ff)
					nxt_level = ramp_step;
			end
			ARG_DECEL:
			begin
				if (level_ff == ss_x10)
				begin
					nxt_state = ARG_HOLD_STOP;
					nxt_hold = '0;
				end
				else if (tick_ff)
					nxt_level = ramp_step;
			end
			ARG_HOLD_STOP:
			begin
				nxt_level = ss_x10;
				nxt_hold = hold_ff + 1'b1;
				if (hold_done)
				begin
					nxt_state = ARG_LOCKED;
					nxt_level = base_x10;
				end
			end
			ARG_LOCKED:
			begin
				nxt_level = base_x10;
				if (!en && !stop)
					nxt_state = ARG_IDLE;
			end
			default:
			begin
				nxt_state = ARG_IDLE;
				nxt_level = base_x10;
			end
		endcase
		if ((state_ff == ARG_HOLD_START || state_ff == ARG_RAMP) && stop)
			nxt_state = ARG_DECEL;
		// Falling enable wins over everything; locked state waits for both to clear
		if (en_fall)
		begin
			nxt_state = ARG_LOCKED;
			nxt_level = base_x10;
		end
		nxt_level = cap(nxt_level, max_x10);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ARG_IDLE;
			level_ff <= '0;
			hold_ff <= '0;
			en_q_ff <= 1'b0;
			running_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			level_ff <= nxt_level;
			hold_ff <= nxt_hold;
			en_q_ff <= en;
			running_ff <= nxt_state != ARG_IDLE && nxt_state != ARG_LOCKED;
		end
	end

	// Scaled output: numerator carries gain's hundredths
	wire signed [ARG_LVL_W-1:0] level_int = level_ff / ARG_STEP_DIV;
	wire signed [ARG_LVL_W-1:0] diff = level_int -
		{{(ARG_LVL_W-ARG_PAR_W){base_ofs_ff[ARG_PAR_W-1]}}, base_ofs_ff};
	wire diff_pos = diff > 0;
	wire [ARG_NUM_W-1:0] div_num = ARG_NUM_W'(diff[ARG_PAR_W-1:0] * ARG_GAIN_SCALE);
	wire div_busy;
	wire div_done;
	wire [ARG_NUM_W-1:0] div_quot;
	wire div_start = ~div_busy & ~div_done;

	arg_divider u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(div_start),
		.numer(div_num),
		.denom(gain_ff),
		.busy(div_busy),
		.done(div_done),
		.quot(div_quot)
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			zero_ff <= 1'b1;
			aq_ff <= '0;
			lvl_out_ff <= '0;
		end
		else
		begin
			lvl_out_ff <= level_int[15:0];
			if (div_start)
				zero_ff <= (gain_ff == '0) || !diff_pos;
			if (div_done)
			begin
				if (zero_ff)
					aq_ff <= '0;
				else if (div_quot > ARG_AQ_MAX)
					aq_ff <= ARG_AQ_MAX[15:0];
				else
					aq_ff <= div_quot[15:0];
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign scaled_analog_out = aq_ff;
	assign current_level = lvl_out_ff;
	assign ramp_running = running_ff;

endmodule : arg_ramp_top

// ---- bench/arg_ramp_sva.sv ----
`timescale 1ns/1ps
module arg_ramp_sva
	import arg_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = ARG_TICK_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Results
	input wire logic [15:0] scaled_analog_out,
	input wire logic signed [15:0] current_level,
	input wire logic ramp_running
);
	localparam int GAP_MIN = TICK_CYCLES - 1;
	logic signed [15:0] lvl_q_ff;
	int gap_ff;
	int idle_ff;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_q_ff <= 16'sh0000;
			gap_ff <= 0;
			idle_ff <= 0;
		end
		else
		begin
			lvl_q_ff <= current_level;
			gap_ff <= (current_level != lvl_q_ff) ? 0 : gap_ff + 1;
			idle_ff <= ramp_running ? 0 : ((idle_ff < 100) ? idle_ff + 1 : idle_ff);
		end
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	a_aq_range: assert property (scaled_analog_out <= 16'h7fff)
		else $error("scaled output above range");
	a_level_max: assert property ($signed(current_level) <= 16'sh4e20)
		else $error("level above the largest maximum");
	// Hold entry and exits jump; only steady running is bounded
	a_step_bound: assert property (ramp_running && $past(ramp_running) && $past(ramp_running, 2)
		|-> (int'(current_level) - int'($past(current_level)) <= 1000)
		&& (int'(current_level) - int'($past(current_level)) >= -1000))
		else $error("level step larger than a tick allows");
	a_tick_gap: assert property (ramp_running && $past(ramp_running) && $past(ramp_running, 2)
		&& (current_level != lvl_q_ff) |-> gap_ff >= GAP_MIN)
		else $error("level changed between ticks");
	a_idle_zero: assert property (idle_ff >= 60 |-> scaled_analog_out == 16'h0000)
		else $error("output not zero while stopped");
	c_start: cover property ($rose(ramp_running));
	c_stop: cover property ($fell(ramp_running));
	c_aq_top: cover property (scaled_analog_out == 16'h7fff);
endmodule : arg_ramp_sva

bind arg_ramp_top arg_ramp_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.scaled_analog_out(scaled_analog_out),
	.current_level(current_level),
	.ramp_running(ramp_running)
);

// ---- bench/arg_load_model.sv ----
`timescale 1ns/1ps
module arg_load_model
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Ramp state seen by the consuming block
	input wire logic ramp_running,
	output logic [7:0] starts_ff
);
	logic seen_ff;
	// Counting starts exposes a restart that should have been refused
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_ff <= 1'b0;
			starts_ff <= 8'h00;
		end
		else
		begin
			seen_ff <= ramp_running;
			if (ramp_running && !seen_ff)
				starts_ff <= starts_ff + 8'h01;
		end
	end
endmodule : arg_load_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import arg_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [15:0] scaled_analog_out;
	logic signed [15:0] current_level;
	logic ramp_running;
	logic [7:0] starts;
	logic [31:0] rd;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	localparam logic [7:0] RST_ADR [8] = '{ARG_REG_CTRL, ARG_REG_FIRST_TGT, ARG_REG_SECOND_TGT,
		ARG_REG_MAX_LEVEL, ARG_REG_SS_OFFSET, ARG_REG_RATE, ARG_REG_GAIN, 8'h3c};
	localparam logic [31:0] RST_VAL [8] = '{32'h0, 32'h0, 32'h0, 32'h4e20, 32'h0, 32'h1,
		32'h64, 32'h0};
	localparam logic [7:0] CL_ADR [5] = '{ARG_REG_FIRST_TGT, ARG_REG_LEVEL, ARG_REG_MAX_LEVEL,
		ARG_REG_SS_OFFSET, ARG_REG_RATE};
	localparam logic [31:0] CL_WR [5] = '{32'h7530, 32'h4d2, 32'hffffb1e0, 32'hfffffffb, 32'h0};
	localparam logic [31:0] CL_EXP [5] = '{32'h4e20, 32'h0, 32'hffffd8f0, 32'h0, 32'h1};

	always #20 core_clk = ~core_clk;

	arg_ramp_top #(.TICK_CYCLES(20), .HOLD_CYCLES(20)) dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.scaled_analog_out(scaled_analog_out),
		.current_level(current_level),
		.ramp_running(ramp_running)
	);

	arg_load_model u_load (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ramp_running(ramp_running),
		.starts_ff(starts)
	);

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Ack and read data are taken at the rising edge that shows ack high
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		chk("bus ack", 32'h1, {31'h0, wb_ack_o});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		bus(1'b1, adr, wd, 4'hf);
	endtask : wr

	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0, 4'hf);
		chk("register", exp, rd);
	endtask : rchk

	task automatic wait_level(input logic signed [15:0] exp, input int lim);
		int n;
		n = 0;
		while (current_level !== exp && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("level", 32'(exp), 32'(current_level));
	endtask : wait_level

	// A division started just before a change keeps the old value; refresh takes up to 52
	task automatic settle_aq(input logic [15:0] exp);
		repeat (60) @(negedge core_clk);
		chk("aq", {16'h0, exp}, {16'h0, scaled_analog_out});
	endtask : settle_aq

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk(RST_ADR[i], RST_VAL[i]);
		for (int i = 0; i < 5; i++)
		begin
			wr(CL_ADR[i], CL_WR[i]);
			rchk(CL_ADR[i], CL_EXP[i]);
		end
		bus(1'b1, ARG_REG_SECOND_TGT, 32'hffffff37, 4'h1);
		rchk(ARG_REG_SECOND_TGT, 32'h37);
		wr(ARG_REG_MAX_LEVEL, 32'h4e20);
		wr(ARG_REG_BASE_OFS, 32'h64);
		wr(ARG_REG_SS_OFFSET, 32'h32);
		wr(ARG_REG_RATE, 32'h3e8);
		wr(ARG_REG_FIRST_TGT, 32'h190);
		wr(ARG_REG_SECOND_TGT, 32'hc8);
		wr(ARG_REG_GAIN, 32'hc8);
		wr(ARG_REG_CTRL, 32'h1);
		wait_level(16'sd150, 10);
		rchk(ARG_REG_STATUS, 32'h9);
		wait_level(16'sd400, 200);
		settle_aq(16'd150);
		rchk(ARG_REG_LEVEL, 32'h190);
		wr(ARG_REG_CTRL, 32'h3);
		wait_level(16'sd200, 200);
		wr(ARG_REG_MAX_LEVEL, 32'h12c);
		wr(ARG_REG_CTRL, 32'h1);
		wait_level(16'sd300, 200);
		repeat (60) @(negedge core_clk);
		wait_level(16'sd300, 0);
		wr(ARG_REG_MAX_LEVEL, 32'h4e20);
		wait_level(16'sd400, 200);
		wr(ARG_REG_CTRL, 32'h5);
		wait_level(16'sd150, 200);
		wait_level(16'sd100, 100);
		settle_aq(16'd0);
		rchk(ARG_REG_STATUS, 32'h5);
		wr(ARG_REG_CTRL, 32'h1);
		repeat (60) @(negedge core_clk);
		wait_level(16'sd100, 0);
		wr(ARG_REG_CTRL, 32'h0);
		wr(ARG_REG_CTRL, 32'h1);
		wait_level(16'sd150, 10);
		wr(ARG_REG_CTRL, 32'h0);
		wait_level(16'sd100, 5);
		wr(ARG_REG_FIRST_TGT, 32'h4e20);
		wr(ARG_REG_RATE, 32'h4e20);
		rchk(ARG_REG_RATE, 32'h2710);
		wr(ARG_REG_GAIN, 32'h1);
		wr(ARG_REG_CTRL, 32'h1);
		wait_level(16'sd20000, 800);
		settle_aq(16'h7fff);
		wr(ARG_REG_GAIN, 32'h0);
		settle_aq(16'h0000);
		wr(ARG_REG_CTRL, 32'h0);
		chk("starts", 32'h3, {24'h0, starts});
		wrap_up();
	end
endmodule : tb_top
